// [hpsd_pkg.sv]
// Constants and types shared by the host port strobe decoder.
package hpsd_pkg;
	localparam int CLK_PERIOD_NS = 20;
	// Wait state that ready holds low after a separate-strobe strobe falls.
	localparam int RDY_WAIT_NS = 40;
	localparam int RDY_WAIT_CYC = (RDY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAIT_W = 4;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RDATA = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_ACCESS = 8'h0c;

	localparam logic [1:0] MODE_HW = 2'h0;
	localparam logic [1:0] MODE_SERIAL = 2'h1;
	localparam logic [1:0] MODE_PARALLEL = 2'h2;
	localparam logic [1:0] CTRL_RST = MODE_HW;
	localparam logic [7:0] RDATA_RST = 8'h00;

	// Bit of the serial command byte that marks a read.
	localparam int SER_RD_BIT = 7;
	localparam logic [2:0] SER_LAST_BIT = 3'h7;

	typedef struct packed {
		logic cs_n;
		logic tsel_hi;
		logic tsel_mid;
		logic tsel_lo;
		logic mux;
		logic style;
		logic oedge_sel;
		logic [4:0] a;
		logic [7:0] bus;
	} hpsd_pins_s;

	localparam hpsd_pins_s PINS_RST = '{cs_n: 1'b1, tsel_hi: 1'b1, tsel_mid: 1'b1,
		tsel_lo: 1'b1, default: '0};

	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [7:0] data;
	} hpsd_acc_s;

	typedef struct packed {
		logic bus_oe;
		logic busy;
		logic oedge_sel;
		logic style;
		logic mux;
		logic [2:0] tmpl;
	} hpsd_stat_s;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CMD = 4'b0010,
		ST_DATA = 4'b0100,
		ST_DONE = 4'b1000
	} hpsd_ser_e;
endpackage

// [hpsd_sync.sv]
// Three-stage pin synchroniser with filtered level and edge pulses.
`timescale 1ns/100ps
module hpsd_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] lvl_q,
	output logic [WIDTH-1:0] rise_q,
	output logic [WIDTH-1:0] fall_q
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] lvl_d;

	// A change counts only once the second and third stages agree.
	assign lvl_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			lvl_q <= RST_VAL;
			rise_q <= '0;
			fall_q <= '0;
		end
		else
		begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
			rise_q <= lvl_d & ~lvl_q;
			fall_q <= ~lvl_d & lvl_q;
		end
	end
endmodule

// [hpsd_host_port.sv]
// Host port strobe decoder: serial and parallel host access plus template select.
//
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
// How it works
// - Hardware mode takes a 3-bit template code, first pin MSB, third pin LSB.
// - Serial output shifts on falling clock edges if edge select high, rising if low.
// - Serial input is sampled on each rising shift-clock edge of the command and data bytes.
// - Separate-strobe mux mode latches bus bits 4:0 on address latch falling edge.
// - Direction-select mux mode latches bus bits 4:0 on address strobe falling edge.
// - Direction pin low means write, high means read.
// - Separate-strobe writes capture the data bus on write strobe rising edge.
// - Direction-select writes sample the data bus on data strobe rising edge.
// - Direction-select reads drive read data on data strobe rising edge.
// - Direction-select non-mux mode latches address bus on data strobe falling edge.
// - Bus style pin low selects separate buses, high selects multiplexed bus.
// - Host style pin low selects direction-select, high selects separate strobes.
// - Separate-strobe ready is low for wait states, high when the cycle may end.
module hpsd_host_port #(
	parameter int ADDR_W = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic cs_n,
	input wire logic template_sel_msb,
	input wire logic template_sel_mid,
	input wire logic template_sel_lsb,
	input wire logic bus_mux_select,
	input wire logic host_style_select,
	input wire logic out_edge_select,
	input wire logic [4:0] addr_in,
	input wire logic [7:0] bus_in,
	output logic [7:0] bus_out,
	output logic bus_oe,
	output logic serial_out_line,
	output logic serial_out_oe,
	output logic ready_out,
	output logic [2:0] template_code,
	output hpsd_pkg::hpsd_acc_s acc
);
	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.
	hpsd_pkg::hpsd_pins_s pins;
	hpsd_pkg::hpsd_pins_s lv;
	hpsd_pkg::hpsd_pins_s rs;
	hpsd_pkg::hpsd_pins_s fl;

	assign pins = {cs_n, template_sel_msb, template_sel_mid, template_sel_lsb,
		bus_mux_select, host_style_select, out_edge_select, addr_in, bus_in};

	hpsd_sync #(
		.WIDTH($bits(hpsd_pkg::hpsd_pins_s)),
		.RST_VAL(hpsd_pkg::PINS_RST)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(pins),
		.lvl_q(lv),
		.rise_q(rs),
		.fall_q(fl)
	);

	////////////////////////////////////////////////////////////////////////////
	// Mode decode and strobe events.
	logic [1:0] mode_q;
	logic [1:0] mode_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic hw;
	logic ser;
	logic ss;
	logic dsel;
	logic mux;
	logic cs_act;
	logic ale_f;
	logic as_f;
	logic wr_f;
	logic wr_r;
	logic rd_f;
	logic dstr_f;
	logic dstr_r;
	logic sclk_r;
	logic sclk_f;

	assign hw = mode_q == hpsd_pkg::MODE_HW;
	assign ser = mode_q == hpsd_pkg::MODE_SERIAL;
	assign ss = (mode_q == hpsd_pkg::MODE_PARALLEL) && lv.style;
	assign dsel = (mode_q == hpsd_pkg::MODE_PARALLEL) && !lv.style;
	assign mux = lv.mux;
	assign cs_act = !lv.cs_n && !hw;
	assign ale_f = ss && mux && cs_act && fl.tsel_hi;
	assign as_f = dsel && mux && cs_act && fl.tsel_hi;
	assign wr_f = ss && cs_act && fl.tsel_lo;
	assign wr_r = ss && cs_act && rs.tsel_lo;
	assign rd_f = ss && cs_act && fl.tsel_mid;
	assign dstr_f = dsel && cs_act && fl.tsel_lo;
	assign dstr_r = dsel && cs_act && rs.tsel_lo;
	assign sclk_r = ser && cs_act && rs.tsel_hi;
	assign sclk_f = ser && cs_act && fl.tsel_hi;

	////////////////////////////////////////////////////////////////////////////
	// Parallel address latch.
	logic [4:0] paddr_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			paddr_q <= '0;
		else if (ale_f || as_f)
			paddr_q <= lv.bus[4:0];
		else if (dsel && !mux && dstr_f)
			paddr_q <= lv.a;
		else if (ss && !mux && (wr_f || rd_f))
			paddr_q <= lv.a;
	end

	////////////////////////////////////////////////////////////////////////////
	// Parallel read drive. Direction-select reads hold the bus until chip select rises.
	logic par_oe_q;
	logic [7:0] pout_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			par_oe_q <= 1'b0;
			pout_q <= '0;
		end
		else if (ss && cs_act && !lv.tsel_mid)
		begin
			par_oe_q <= 1'b1;
			pout_q <= rdata_q;
		end
		else if (dstr_r && lv.tsel_mid)
		begin
			par_oe_q <= 1'b1;
			pout_q <= rdata_q;
		end
		else if (!cs_act || !dsel)
			par_oe_q <= 1'b0;
	end

	assign bus_out = pout_q;
	assign bus_oe = par_oe_q;

	////////////////////////////////////////////////////////////////////////////
	// Ready: a fixed wait state after each separate-strobe strobe falls.
	logic [hpsd_pkg::WAIT_W-1:0] wcnt_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wcnt_q <= '0;
		else if (rd_f || wr_f)
			wcnt_q <= hpsd_pkg::WAIT_W'(hpsd_pkg::RDY_WAIT_CYC);
		else if (wcnt_q != '0)
			wcnt_q <= wcnt_q - 1'b1;
	end

	assign ready_out = !(ss && cs_act && (wcnt_q != '0));

	////////////////////////////////////////////////////////////////////////////
	// Serial frame: command byte then data byte, both most significant bit first.
	hpsd_pkg::hpsd_ser_e st_q;
	logic [2:0] bcnt_q;
	logic [7:0] ssr_q;
	logic [7:0] sin_byte;
	logic ser_rd_q;
	logic [4:0] saddr_q;
	logic cmd_end;
	logic data_end;

	assign sin_byte = {ssr_q[6:0], lv.tsel_lo};
	assign cmd_end = sclk_r && (st_q == hpsd_pkg::ST_CMD) && (bcnt_q == hpsd_pkg::SER_LAST_BIT);
	assign data_end = sclk_r && (st_q == hpsd_pkg::ST_DATA) && (bcnt_q == hpsd_pkg::SER_LAST_BIT);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_q <= hpsd_pkg::ST_IDLE;
			bcnt_q <= '0;
		end
		else if (!ser || !cs_act)
		begin
			st_q <= hpsd_pkg::ST_IDLE;
			bcnt_q <= '0;
		end
		else
		begin
			case (st_q)
				hpsd_pkg::ST_IDLE: st_q <= hpsd_pkg::ST_CMD;
				hpsd_pkg::ST_CMD, hpsd_pkg::ST_DATA:
				begin
					if (sclk_r)
						bcnt_q <= bcnt_q + 3'h1;
					if (cmd_end)
						st_q <= hpsd_pkg::ST_DATA;
					else if (data_end)
						st_q <= hpsd_pkg::ST_DONE;
				end
				hpsd_pkg::ST_DONE: st_q <= hpsd_pkg::ST_DONE;
				default: st_q <= hpsd_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ssr_q <= '0;
			ser_rd_q <= 1'b0;
			saddr_q <= '0;
		end
		else
		begin
			if (sclk_r && (st_q == hpsd_pkg::ST_CMD || st_q == hpsd_pkg::ST_DATA))
				ssr_q <= sin_byte;
			if (cmd_end)
			begin
				ser_rd_q <= sin_byte[hpsd_pkg::SER_RD_BIT];
				saddr_q <= sin_byte[4:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial output. Writes drive zero during the data byte.
	logic so_q;
	logic so_oe_q;
	logic [7:0] osr_q;
	logic [7:0] so_load;
	logic oedge;

	assign so_load = sin_byte[hpsd_pkg::SER_RD_BIT] ? rdata_q : 8'h00;
	assign oedge = lv.oedge_sel ? sclk_f : sclk_r;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			so_q <= 1'b0;
			osr_q <= '0;
		end
		else if (cmd_end)
		begin
			if (lv.oedge_sel)
				osr_q <= so_load;
			else
			begin
				so_q <= so_load[7];
				osr_q <= {so_load[6:0], 1'b0};
			end
		end
		else if (oedge && st_q == hpsd_pkg::ST_DATA)
		begin
			so_q <= osr_q[7];
			osr_q <= {osr_q[6:0], 1'b0};
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			so_oe_q <= 1'b0;
		else
			so_oe_q <= ser && cs_act && (st_q == hpsd_pkg::ST_DATA || st_q == hpsd_pkg::ST_DONE);
	end

	assign serial_out_line = so_q;
	assign serial_out_oe = so_oe_q;

	////////////////////////////////////////////////////////////////////////////
	// Access events towards the register file.
	hpsd_pkg::hpsd_acc_s acc_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			acc_q <= '0;
		else
		begin
			acc_q.wr <= 1'b0;
			acc_q.rd <= 1'b0;
			if (wr_r || (dstr_r && !lv.tsel_mid))
			begin
				acc_q.wr <= 1'b1;
				acc_q.addr <= paddr_q;
				acc_q.data <= lv.bus;
			end
			else if (rd_f || (dstr_f && lv.tsel_mid))
			begin
				acc_q.rd <= 1'b1;
				acc_q.addr <= mux ? paddr_q : lv.a;
				acc_q.data <= rdata_q;
			end
			else if (data_end && !ser_rd_q)
			begin
				acc_q.wr <= 1'b1;
				acc_q.addr <= saddr_q;
				acc_q.data <= sin_byte;
			end
			else if (cmd_end && sin_byte[hpsd_pkg::SER_RD_BIT])
			begin
				acc_q.rd <= 1'b1;
				acc_q.addr <= sin_byte[4:0];
				acc_q.data <= rdata_q;
			end
		end
	end

	assign acc = acc_q;

	////////////////////////////////////////////////////////////////////////////
	// Hardware template select.
	logic [2:0] tmpl_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tmpl_q <= '0;
		else if (hw)
			tmpl_q <= {lv.tsel_hi, lv.tsel_mid, lv.tsel_lo};
	end

	assign template_code = tmpl_q;

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states, always OKAY.
	logic aphase;
	logic wpend_q;
	logic [7:0] waddr_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_val;
	hpsd_pkg::hpsd_stat_s stat;

	assign aphase = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign stat = {par_oe_q, st_q != hpsd_pkg::ST_IDLE, lv.oedge_sel, lv.style, lv.mux, tmpl_q};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wpend_q <= 1'b0;
			waddr_q <= '0;
		end
		else
		begin
			wpend_q <= aphase && hwrite;
			if (aphase)
				waddr_q <= haddr[7:0];
		end
	end

	// Next values also feed reads, so a read right behind a write sees the new data.
	always_comb
	begin
		mode_d = mode_q;
		rdata_d = rdata_q;
		if (wpend_q && waddr_q == hpsd_pkg::OFS_CTRL)
			mode_d = hwdata[1:0];
		if (wpend_q && waddr_q == hpsd_pkg::OFS_RDATA)
			rdata_d = hwdata[7:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mode_q <= hpsd_pkg::CTRL_RST;
			rdata_q <= hpsd_pkg::RDATA_RST;
		end
		else
		begin
			mode_q <= mode_d;
			rdata_q <= rdata_d;
		end
	end

	always_comb
	begin
		rd_val = '0;
		case (haddr[7:0])
			hpsd_pkg::OFS_CTRL: rd_val = 32'(mode_d);
			hpsd_pkg::OFS_RDATA: rd_val = 32'(rdata_d);
			hpsd_pkg::OFS_STATUS: rd_val = 32'(stat);
			hpsd_pkg::OFS_ACCESS: rd_val = 32'({acc_q.addr, acc_q.data});
			default: rd_val = '0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_q <= '0;
		else if (aphase && !hwrite)
			hrdata_q <= rd_val;
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions.
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_strobe_fall;
		rd_f || wr_f;
	endsequence

	sequence s_ds_read_edge;
		dstr_r && lv.tsel_mid;
	endsequence

	a_tmpl_order: assert property (hw |=> tmpl_q == $past({lv.tsel_hi, lv.tsel_mid, lv.tsel_lo}))
		else $error("Template code does not follow the select pins.");
	a_hw_no_strobe: assert property (hw |=> !acc_q.wr && !acc_q.rd && !par_oe_q)
		else $error("Strobe acted in hardware mode.");
	a_ser_sample: assert property (sclk_r && st_q == hpsd_pkg::ST_CMD |=> ssr_q[0] == $past(lv.tsel_lo))
		else $error("Serial input not sampled on rising edge.");
	a_ser_edge_hold: assert property (!oedge |=> $stable(so_q))
		else $error("Serial output changed off its selected edge.");
	a_ser_edge_bit: assert property (oedge && st_q == hpsd_pkg::ST_DATA |=> so_q == $past(osr_q[7]))
		else $error("Serial output missed a bit on its edge.");
	a_ale_addr: assert property (ale_f |=> paddr_q == $past(lv.bus[4:0]))
		else $error("Address latch edge did not capture bus bits.");
	a_as_addr: assert property (as_f |=> paddr_q == $past(lv.bus[4:0]))
		else $error("Address strobe edge did not capture bus bits.");
	a_ds_addr: assert property (dsel && !mux && dstr_f |=> paddr_q == $past(lv.a))
		else $error("Data strobe fall did not latch the address bus.");
	a_wr_capture: assert property (wr_r |=> acc_q.wr && acc_q.data == $past(lv.bus))
		else $error("Write strobe rise did not capture data.");
	a_ds_write: assert property (dstr_r && !lv.tsel_mid |=> acc_q.wr && acc_q.data == $past(lv.bus))
		else $error("Data strobe rise did not capture write data.");
	a_ds_read: assert property (s_ds_read_edge |=> bus_oe && bus_out == $past(rdata_q))
		else $error("Data strobe rise did not drive read data.");
	a_ready_low: assert property (s_strobe_fall ##1 (ss && cs_act) |-> !ready_out)
		else $error("Ready not low in the wait state.");
	a_ready_high: assert property (s_strobe_fall ##1 (ss && cs_act && !rd_f && !wr_f)[*3] |-> ready_out)
		else $error("Ready not released after the wait state.");
endmodule

// [hpsd_host_model.sv]
// Host model that drives the shared control pins in serial and parallel styles.
`timescale 1ns/100ps
module hpsd_host_model (
	input wire logic hclk,
	input wire logic ready_out,
	input wire logic serial_out_line,
	input wire logic [7:0] bus_in,
	output logic cs_n,
	output logic template_sel_msb,
	output logic template_sel_mid,
	output logic template_sel_lsb,
	output logic bus_mux_select,
	output logic host_style_select,
	output logic out_edge_select,
	output logic [4:0] addr_in,
	output logic [7:0] bus_drv
);
	initial
	begin
		cs_n = 1'b1;
		{template_sel_msb, template_sel_mid, template_sel_lsb} = 3'h7;
		{bus_mux_select, host_style_select, out_edge_select} = 3'h0;
		addr_in = 5'h00;
		bus_drv = 8'h00;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge hclk);
	endtask

	task automatic cfg(input logic [2:0] mso, input logic [2:0] pins);
		{bus_mux_select, host_style_select, out_edge_select} <= mso;
		{template_sel_msb, template_sel_mid, template_sel_lsb} <= pins;
		tk(8);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// A released bus shows the inverse of its last value, so stale data never matches.
	task automatic par_access(input logic rd, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] q);
		q = 8'h00;
		cs_n <= 1'b0;
		if (!host_style_select) template_sel_mid <= rd;
		addr_in <= a;
		bus_drv <= {3'h7, a};
		tk(6);
		if (bus_mux_select) template_sel_msb <= 1'b0;
		tk(6);
		bus_drv <= rd ? ~bus_drv : d;
		if (host_style_select && rd) template_sel_mid <= 1'b0;
		else template_sel_lsb <= 1'b0;
		tk(8);
		while (!ready_out) tk(1);
		if (host_style_select && rd) q = bus_in;
		if (host_style_select && rd) template_sel_mid <= 1'b1;
		else template_sel_lsb <= 1'b1;
		tk(8);
		if (!host_style_select && rd) q = bus_in;
		cs_n <= 1'b1;
		template_sel_msb <= 1'b1;
		template_sel_mid <= 1'b1;
		bus_drv <= ~bus_drv;
		tk(8);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// The shift clock runs only inside the frame, with a half period of four cycles.
	task automatic ser_frame(input logic [15:0] sh, output logic [7:0] q);
		q = 8'h00;
		template_sel_msb <= 1'b0;
		cs_n <= 1'b0;
		tk(6);
		for (int i = 0; i < 16; i++)
		begin
			template_sel_lsb <= sh[15 - i];
			tk(3);
			#1;
			if (!out_edge_select && i >= 8) q = {q[6:0], serial_out_line};
			@(posedge hclk) template_sel_msb <= 1'b1;
			tk(3);
			#1;
			if (out_edge_select && i >= 8) q = {q[6:0], serial_out_line};
			@(posedge hclk) template_sel_msb <= 1'b0;
		end
		tk(6);
		cs_n <= 1'b1;
		tk(6);
	endtask
endmodule

// [test_host_port_strobe_decode.sv]
// Self-checking bench for the host port strobe decoder.
`timescale 1ns/100ps
module test_host_port_strobe_decode;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rv;
	logic hreadyout, hresp, cs_n, t_msb, t_mid, t_lsb, mux, style, oes;
	logic bus_oe, sout, sout_oe, ready_out;
	logic [4:0] addr_in, a;
	logic [7:0] bus_in, bus_out, bus_drv, q, d;
	logic [2:0] template_code, k;
	logic [2:0] kinds [5] = '{3'b110, 3'b111, 3'b010, 3'b001, 3'b100};
	hpsd_pkg::hpsd_acc_s acc;
	int num_errors = 0, checks_done = 0, wr_cnt = 0, rd_cnt = 0, rdy_low = 0;
	int n_wr, n_rd, n_rdy, n_oe;
	int oe_cnt = 0;

	always #(hpsd_pkg::CLK_PERIOD_NS / 2) hclk = ~hclk;
	assign bus_in = bus_oe ? bus_out : bus_drv;

	hpsd_host_port u_hpsd_host_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cs_n(cs_n), .template_sel_msb(t_msb), .template_sel_mid(t_mid),
		.template_sel_lsb(t_lsb), .bus_mux_select(mux), .host_style_select(style),
		.out_edge_select(oes), .addr_in(addr_in), .bus_in(bus_in), .bus_out(bus_out),
		.bus_oe(bus_oe), .serial_out_line(sout), .serial_out_oe(sout_oe),
		.ready_out(ready_out), .template_code(template_code), .acc(acc));

	hpsd_host_model u_hpsd_host_model (.hclk(hclk), .ready_out(ready_out),
		.serial_out_line(sout), .bus_in(bus_in), .cs_n(cs_n), .template_sel_msb(t_msb),
		.template_sel_mid(t_mid), .template_sel_lsb(t_lsb), .bus_mux_select(mux),
		.host_style_select(style), .out_edge_select(oes), .addr_in(addr_in),
		.bus_drv(bus_drv));

	always @(posedge hclk)
	begin
		if (acc.wr === 1'b1) wr_cnt <= wr_cnt + 1;
		if (acc.rd === 1'b1) rd_cnt <= rd_cnt + 1;
		if (ready_out === 1'b0) rdy_low <= rdy_low + 1;
		if (sout_oe === 1'b1) oe_cnt <= oe_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= ad;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic stop_test;
		if (num_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#200000;
		num_errors++;
		stop_test();
	end

	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		u_hpsd_host_model.tk(2);
		ahb(1'b0, hpsd_pkg::OFS_CTRL, 32'h0, rv);
		chk(rv, 32'h0);
		chk({30'h0, hreadyout, hresp}, 32'h2);
		ahb(1'b1, hpsd_pkg::OFS_RDATA, 32'ha5, rv);
		ahb(1'b0, hpsd_pkg::OFS_RDATA, 32'h0, rv);
		chk(rv, 32'ha5);
		ahb(1'b0, 8'h10, 32'h0, rv);
		chk(rv, 32'h0);
		// Hardware mode: pins are template levels and strobes do nothing.
		u_hpsd_host_model.cfg(3'b011, 3'h4);
		chk({29'h0, template_code}, 32'h4);
		u_hpsd_host_model.cfg(3'b011, 3'h3);
		chk({29'h0, template_code}, 32'h3);
		n_wr = wr_cnt + rd_cnt;
		u_hpsd_host_model.cfg(3'b011, 3'h7);
		u_hpsd_host_model.par_access(1'b0, 5'h02, 8'h11, q);
		chk(wr_cnt + rd_cnt, n_wr);
		ahb(1'b0, hpsd_pkg::OFS_STATUS, 32'h0, rv);
		chk(rv, 32'h37);
		// Parallel styles: {mux, style, read} for each access.
		ahb(1'b1, hpsd_pkg::OFS_CTRL, {30'h0, hpsd_pkg::MODE_PARALLEL}, rv);
		for (int i = 0; i < 5; i++)
		begin
			k = kinds[i];
			a = 5'(3 + 7 * i);
			d = 8'(8'h3c + 8'h11 * i);
			u_hpsd_host_model.cfg({k[2:1], 1'b0}, 3'h7);
			n_wr = wr_cnt;
			n_rd = rd_cnt;
			n_rdy = rdy_low;
			u_hpsd_host_model.par_access(k[0], a, d, q);
			chk(k[0] ? rd_cnt - n_rd : wr_cnt - n_wr, 1);
			chk({27'h0, acc.addr}, {27'h0, a});
			chk(rdy_low - n_rdy, k[1] ? hpsd_pkg::RDY_WAIT_CYC : 0);
			chk({31'h0, bus_oe}, 32'h0);
			if (k[0])
				chk({24'h0, q}, 32'ha5);
			else
			begin
				chk({24'h0, acc.data}, {24'h0, d});
				ahb(1'b0, hpsd_pkg::OFS_ACCESS, 32'h0, rv);
				chk(rv, {19'h0, a, d});
			end
		end
		// Serial frames: read on rising, read on falling, then a write.
		ahb(1'b1, hpsd_pkg::OFS_CTRL, {30'h0, hpsd_pkg::MODE_SERIAL}, rv);
		for (int j = 0; j < 3; j++)
		begin
			a = 5'(9 + j);
			u_hpsd_host_model.cfg({2'b00, j != 0}, 3'h7);
			n_wr = wr_cnt;
			n_rd = rd_cnt;
			n_oe = oe_cnt;
			u_hpsd_host_model.ser_frame(j < 2 ? {3'h4, a, 8'h00} : {3'h0, a, 8'h9a}, q);
			chk(32'(oe_cnt > n_oe), 32'h1);
			chk({31'h0, sout_oe}, 32'h0);
			chk({24'h0, q}, j < 2 ? 32'ha5 : 32'h0);
			chk(j < 2 ? rd_cnt - n_rd : wr_cnt - n_wr, 1);
			chk({27'h0, acc.addr}, {27'h0, a});
			if (j == 2) chk({24'h0, acc.data}, 32'h9a);
		end
		stop_test();
	end
endmodule
